/* bie_pkg.sv */
// Purpose: Shared constants and types for the branch, increment and OR execution slice.
// Assumes: A fetch stage hands over each decoded instruction with its operand bytes.
// Notes:   Widths, PC, register and accumulator reset values and lengths live here; status and stack pointer resets stay in bie_exec.
// ============================================================================
// Functional notes
// RQ1: Register increment adds one, wraps FFF to 000.
// RQ2: OR accumulator with register low byte.
// RQ3: OR clears carry, half-carry; sets nonzero status.
// RQ4: Increment-and-branch jumps unless low byte is zero.
// RQ5: Relative target uses page after the branch.
// RQ6: Jump on carry when carry is one.
// RQ7: Jump on no carry when carry is zero.
// RQ8: Greater jump needs no carry and nonzero.
// RQ9: Jump on half-carry when it is one.
// RQ10: Less-or-equal jump on carry or zero.
// RQ11: Jump on nonzero when nonzero status is one.
// RQ12: Comparison aliases decode as their base jumps.
// RQ13: Indirect jump loads PC from register.
// RQ14: Call pushes next address, loads 12-bit target.
// RQ15: Unconditional jump always loads its target.
// RQ16: Jump on zero when nonzero status is zero.
// RQ17: Return pops top of stack into PC.
// RQ18: Upper four bits are page, lower eight byte.
// RQ19: Relative target keeps page, replaces low byte.
// RQ20: Untaken branch advances past both bytes.
package bie_pkg;

    // ========================================================================
    // Widths and field positions.
    localparam int ADDR_W     = 12;  // Program counter and register width.
    localparam int DATA_W     = 8;   // Accumulator width.
    localparam int PAGE_LSB   = 8;   // Lowest page bit of an address.
    localparam int REG_CNT    = 8;   // General registers R0 to R7.
    localparam int REG_SEL_W  = 3;   // Register select width.
    localparam int STACK_DEPTH = 8;  // Default stack entries.

    // ========================================================================
    // Reset values and instruction lengths.
    localparam logic [ADDR_W-1:0] PC_RST   = 12'h000;
    localparam logic [ADDR_W-1:0] REG_RST  = 12'h000;
    localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
    localparam logic [ADDR_W-1:0] ONE_A    = 12'h001;
    localparam logic [ADDR_W-1:0] LEN_ONE  = 12'h001;
    localparam logic [ADDR_W-1:0] LEN_TWO  = 12'h002;
    localparam logic [DATA_W-1:0] ZERO_B   = 8'h00;

    // ========================================================================
    // Operations this slice executes.
    typedef enum logic [4:0] {
        bie_reg_increment_op,
        bie_inclusive_or_op,
        bie_increment_branch_op,
        bie_decrement_branch_op,
        bie_jump_on_carry_op,
        bie_jump_no_carry_op,
        bie_jump_greater_op,
        bie_jump_greater_equal_op,
        bie_jump_half_carry_op,
        bie_jump_less_equal_op,
        bie_jump_less_op,
        bie_jump_nonzero_op,
        bie_jump_not_equal_op,
        bie_jump_zero_op,
        bie_jump_equal_op,
        bie_register_indirect_jump_op,
        bie_subroutine_call_op,
        bie_unconditional_jump_op,
        bie_subroutine_return_op
    } bie_op_t;

    // Execution sequencer states.
    typedef enum logic [0:0] {
        bie_idle_s,
        bie_pop_s
    } bie_state_t;

endpackage

/* bie_stack_mem.sv */
// Purpose: Return address stack storage with registered read data.
// Assumes: One write and one read address per cycle, same clock.
// Notes:   Read data lag the read address by one clock edge.
`timescale 1ns/1ps
module bie_stack_mem #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // Clock.
    input  wire logic                     clock_i,
    // Write port.
    input  wire logic                     wr_en_i,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
    input  wire logic [WIDTH-1:0]         wr_data_i,
    // Read port.
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
    output logic      [WIDTH-1:0]         rd_data_o
);

    // ========================================================================
    // Storage array; contents are undefined until written.
    logic [WIDTH-1:0] mem_ff [DEPTH];

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
        $error("Stack depth must be a power of two of at least two.");
    end

    // Write on enable.
    always_ff @(posedge clock_i) begin
        if (wr_en_i) begin
            mem_ff[wr_addr_i] <= wr_data_i;
        end
    end

    // Read out of a register so the pop path starts on a clean edge.
    always_ff @(posedge clock_i) begin
        rd_data_o <= mem_ff[rd_addr_i];
    end

endmodule

/* bie_exec.sv */
// Purpose: Executes increment, OR, page-relative and absolute jumps, call, return.
// Assumes: Decoded op and operand bytes arrive from a fetch stage on the same clock.
// Notes:   Holds PC, accumulator, statuses, registers and the call stack.
`timescale 1ns/1ps
module bie_exec
    import bie_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    // Clock and reset.
    input  wire logic                 clock_i,
    input  wire logic                 rst_n_i,
    // Instruction hand-over.
    input  wire logic                 exec_i,
    input  wire bie_op_t              op_i,
    input  wire logic [REG_SEL_W-1:0] reg_sel_i,
    input  wire logic [DATA_W-1:0]    byte2_i,
    input  wire logic [ADDR_W-1:0]    target_i,
    // State preload from the rest of the processor.
    input  wire logic                 reg_wr_i,
    input  wire logic [REG_SEL_W-1:0] reg_wr_sel_i,
    input  wire logic [ADDR_W-1:0]    reg_wr_data_i,
    input  wire logic                 stat_wr_i,
    input  wire logic [DATA_W-1:0]    acc_wr_data_i,
    input  wire logic                 carry_wr_i,
    input  wire logic                 half_wr_i,
    input  wire logic                 nonzero_wr_i,
    // Architectural state out.
    output logic      [ADDR_W-1:0]    pc_o,
    output logic      [DATA_W-1:0]    acc_o,
    output logic                      carry_o,
    output logic                      half_o,
    output logic                      nonzero_o,
    output logic      [$clog2(DEPTH)-1:0] depth_o,
    // Handshake.
    output logic                      busy_o,
    output logic                      done_o
);

    localparam int SP_W = $clog2(DEPTH);

    if (DEPTH < 2) begin
        $error("Stack depth below two is not supported.");
    end

    // ========================================================================
    // State.
    logic [ADDR_W-1:0] pc_ff;               // Program counter.
    logic [DATA_W-1:0] acc_ff;              // Accumulator.
    logic              c_ff;                // Carry status.
    logic              h_ff;                // Half-carry status.
    logic              a_ff;                // Accumulator-nonzero status.
    logic [ADDR_W-1:0] rf_ff [REG_CNT];     // General registers.
    logic [SP_W-1:0]   sp_ff;               // Next free stack slot.
    logic              done_ff;             // One-cycle completion pulse.
    logic              busy_ff;             // High while a pop is pending.
    bie_state_t        state_ff;            // Sequencer state.
    bie_state_t        nxt_state;

    // ========================================================================
    // Decode.
    wire               take     = exec_i && state_ff == bie_idle_s;
    wire [ADDR_W-1:0]  rv       = rf_ff[reg_sel_i];
    wire [ADDR_W-1:0]  inc_val  = rv + ONE_A;                           // RQ1
    wire [ADDR_W-1:0]  dec_val  = rv - ONE_A;
    wire [DATA_W-1:0]  or_val   = acc_ff | rv[DATA_W-1:0];              // RQ2
    wire [ADDR_W-1:0]  seq1     = pc_ff + LEN_ONE;
    wire [ADDR_W-1:0]  seq2     = pc_ff + LEN_TWO;                      // RQ20
    // Page comes from the instruction after the branch, so a branch that
    // ends on a page boundary lands in the following page.
    wire [ADDR_W-1:0]  rel_tgt  = {seq2[ADDR_W-1:PAGE_LSB], byte2_i};   // RQ5 RQ18 RQ19

    wire is_inc   = op_i == bie_reg_increment_op;
    wire is_or    = op_i == bie_inclusive_or_op;
    wire is_ibr   = op_i == bie_increment_branch_op;
    wire is_dbr   = op_i == bie_decrement_branch_op;
    wire is_jin   = op_i == bie_register_indirect_jump_op;
    wire is_call  = op_i == bie_subroutine_call_op;
    wire is_jun   = op_i == bie_unconditional_jump_op;
    wire is_ret   = op_i == bie_subroutine_return_op;
    // The less, greater-or-equal, not-equal and equal forms share the base condition.
    wire on_c     = op_i == bie_jump_on_carry_op || op_i == bie_jump_less_op;         // RQ12
    wire on_nc    = op_i == bie_jump_no_carry_op
                    || op_i == bie_jump_greater_equal_op;                             // RQ12
    wire on_nz    = op_i == bie_jump_nonzero_op || op_i == bie_jump_not_equal_op;     // RQ12
    wire on_z     = op_i == bie_jump_zero_op || op_i == bie_jump_equal_op;            // RQ12
    wire on_gt    = op_i == bie_jump_greater_op;
    wire on_le    = op_i == bie_jump_less_equal_op;
    wire on_hc    = op_i == bie_jump_half_carry_op;
    wire is_cond  = on_c | on_nc | on_nz | on_z | on_gt | on_le | on_hc;
    wire is_rel   = is_cond | is_ibr | is_dbr;

    // Branch condition for every page-relative form.
    wire cond_take = (on_c & c_ff)                                      // RQ6
                   | (on_nc & ~c_ff)                                    // RQ7
                   | (on_gt & ~c_ff & a_ff)                             // RQ8
                   | (on_hc & h_ff)                                     // RQ9
                   | (on_le & (c_ff | ~a_ff))                           // RQ10
                   | (on_nz & a_ff)                                     // RQ11
                   | (on_z & ~a_ff)                                     // RQ16
                   | (is_ibr & (inc_val[DATA_W-1:0] != ZERO_B))         // RQ4
                   | (is_dbr & (dec_val[DATA_W-1:0] != ZERO_B));

    // Next PC for everything except return, which takes the stack data.
    wire [ADDR_W-1:0] nxt_pc =
        (is_rel && cond_take) ? rel_tgt :                               // RQ19
        is_rel                ? seq2    :                               // RQ20
        is_jin                ? rv      :                               // RQ13
        (is_call || is_jun)   ? target_i :                              // RQ14 RQ15
                                seq1;

    // Stack ports: push at the free slot, read always the top entry.
    wire              push    = take && is_call;
    wire [SP_W-1:0]   top_idx = sp_ff - SP_W'(1);
    wire [ADDR_W-1:0] pop_data;

    // ========================================================================
    // Call stack storage.
    bie_stack_mem #(
        .WIDTH (ADDR_W),
        .DEPTH (DEPTH)
    ) u_stack (
        .clock_i   (clock_i),
        .wr_en_i   (push),
        .wr_addr_i (sp_ff),
        .wr_data_i (seq2),                                              // RQ14
        .rd_addr_i (top_idx),
        .rd_data_o (pop_data)
    );

    // ========================================================================
    // Sequencer: return needs one extra edge for the stack read.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            bie_idle_s: begin
                if (take && is_ret) begin
                    nxt_state = bie_pop_s;
                end
            end
            bie_pop_s: begin
                nxt_state = bie_idle_s;
            end
            default: begin
                nxt_state = bie_idle_s;
            end
        endcase
    end

    // State register and handshake pulses.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_ff <= bie_idle_s;
            done_ff  <= 1'b0;
            busy_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            done_ff  <= (take && !is_ret) || state_ff == bie_pop_s;
            busy_ff  <= nxt_state == bie_pop_s;
        end
    end

    // Program counter and stack pointer.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pc_ff <= PC_RST;
            sp_ff <= '0;
        end else if (state_ff == bie_pop_s) begin
            pc_ff <= pop_data;                                          // RQ17
            sp_ff <= top_idx;                                           // RQ17
        end else if (take && !is_ret) begin
            pc_ff <= nxt_pc;
            if (is_call) begin
                sp_ff <= sp_ff + SP_W'(1);                              // RQ14
            end
        end
    end

    // Accumulator and statuses; a preload yields to an executing OR.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            acc_ff <= ACC_RST;
            c_ff   <= 1'b0;
            h_ff   <= 1'b0;
            a_ff   <= 1'b0;
        end else if (take && is_or) begin
            acc_ff <= or_val;                                           // RQ2
            c_ff   <= 1'b0;                                             // RQ3
            h_ff   <= 1'b0;                                             // RQ3
            a_ff   <= or_val != ZERO_B;                                 // RQ3
        end else if (stat_wr_i) begin
            acc_ff <= acc_wr_data_i;
            c_ff   <= carry_wr_i;
            h_ff   <= half_wr_i;
            a_ff   <= nonzero_wr_i;
        end
    end

    // General registers: increment forms win over a preload in one cycle.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < REG_CNT; i++) begin
                rf_ff[i] <= REG_RST;
            end
        end else if (take && (is_inc || is_ibr)) begin
            rf_ff[reg_sel_i] <= inc_val;                                // RQ1 RQ4
        end else if (take && is_dbr) begin
            rf_ff[reg_sel_i] <= dec_val;
        end else if (reg_wr_i) begin
            rf_ff[reg_wr_sel_i] <= reg_wr_data_i;
        end
    end

    // ========================================================================
    // Outputs straight from flops.
    assign pc_o      = pc_ff;
    assign acc_o     = acc_ff;
    assign carry_o   = c_ff;
    assign half_o    = h_ff;
    assign nonzero_o = a_ff;
    assign depth_o   = sp_ff;
    assign busy_o    = busy_ff;
    assign done_o    = done_ff;

    // ========================================================================
    // Checking helpers: snapshot of the taken instruction and its inputs.
    logic              k_take_ff;
    bie_op_t           k_op_ff;
    logic [REG_SEL_W-1:0] k_sel_ff;
    logic [ADDR_W-1:0] k_rv_ff;
    logic [ADDR_W-1:0] k_pc_ff;
    logic [DATA_W-1:0] k_acc_ff;
    logic [DATA_W-1:0] k_b2_ff;
    logic [ADDR_W-1:0] k_tgt_ff;
    logic              k_c_ff;
    logic              k_h_ff;
    logic              k_a_ff;
    wire [ADDR_W-1:0]  k_seq2 = k_pc_ff + LEN_TWO;
    wire [ADDR_W-1:0]  k_rel  = {k_seq2[ADDR_W-1:PAGE_LSB], k_b2_ff};

    always_ff @(posedge clock_i) begin
        k_take_ff <= rst_n_i && take;
        k_op_ff   <= op_i;
        k_sel_ff  <= reg_sel_i;
        k_rv_ff   <= rv;
        k_pc_ff   <= pc_ff;
        k_acc_ff  <= acc_ff;
        k_b2_ff   <= byte2_i;
        k_tgt_ff  <= target_i;
        k_c_ff    <= c_ff;
        k_h_ff    <= h_ff;
        k_a_ff    <= a_ff;
    end

    a_inc_wraps: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ1
        k_take_ff && k_op_ff == bie_reg_increment_op
        |-> rf_ff[k_sel_ff] == ADDR_W'(k_rv_ff + 12'h001) && pc_o == k_pc_ff + LEN_ONE)
        else $error("Register increment result wrong.");

    a_or_value: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ2
        k_take_ff && k_op_ff == bie_inclusive_or_op
        |-> acc_o == (k_acc_ff | k_rv_ff[7:0]))
        else $error("OR result wrong.");

    a_or_status: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ3
        k_take_ff && k_op_ff == bie_inclusive_or_op
        |-> !carry_o && !half_o && nonzero_o == (acc_o != 8'h00))
        else $error("OR statuses wrong.");

    a_incbr_pc: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ4
        k_take_ff && k_op_ff == bie_increment_branch_op
        |-> pc_o == ((ADDR_W'(k_rv_ff + 12'h001) & 12'h0ff) == 12'h000 ? k_seq2 : k_rel))
        else $error("Increment branch target wrong.");

    a_carry_jump: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ6
        k_take_ff && (k_op_ff == bie_jump_on_carry_op || k_op_ff == bie_jump_less_op)
        |-> pc_o == (k_c_ff ? k_rel : k_seq2))
        else $error("Carry jump wrong.");

    a_nocarry_jump: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ7
        k_take_ff && (k_op_ff == bie_jump_no_carry_op
                      || k_op_ff == bie_jump_greater_equal_op)
        |-> pc_o == (!k_c_ff ? k_rel : k_seq2))
        else $error("No-carry jump wrong.");

    a_greater_jump: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ8
        k_take_ff && k_op_ff == bie_jump_greater_op
        |-> pc_o == ((!k_c_ff && k_a_ff) ? k_rel : k_seq2))
        else $error("Greater jump wrong.");

    a_half_jump: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ9
        k_take_ff && k_op_ff == bie_jump_half_carry_op
        |-> pc_o == (k_h_ff ? k_rel : k_seq2))
        else $error("Half-carry jump wrong.");

    a_le_jump: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ10
        k_take_ff && k_op_ff == bie_jump_less_equal_op
        |-> pc_o == ((k_c_ff || !k_a_ff) ? k_rel : k_seq2))
        else $error("Less-or-equal jump wrong.");

    a_zero_jump: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ16
        k_take_ff && (k_op_ff == bie_jump_zero_op || k_op_ff == bie_jump_equal_op)
        |-> pc_o == (!k_a_ff ? k_rel : k_seq2))
        else $error("Zero jump wrong.");

    a_nz_jump: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ11
        k_take_ff && (k_op_ff == bie_jump_nonzero_op || k_op_ff == bie_jump_not_equal_op)
        |-> pc_o == (k_a_ff ? k_rel : k_seq2))
        else $error("Nonzero jump wrong.");

    a_abs_jumps: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ13 RQ15
        k_take_ff && (k_op_ff == bie_register_indirect_jump_op
                      || k_op_ff == bie_unconditional_jump_op)
        |-> pc_o == (k_op_ff == bie_unconditional_jump_op ? k_tgt_ff : k_rv_ff))
        else $error("Absolute jump wrong.");

    a_call_return: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ14 RQ17
        k_take_ff && k_op_ff == bie_subroutine_call_op ##1 (!k_take_ff && take && is_ret)
        |-> pc_o == $past(k_tgt_ff) ##2 pc_o == $past(k_seq2, 3) && done_o)
        else $error("Call and return pairing wrong.");

endmodule

/* bie_prog_mem.sv */
// Purpose: Program memory model that returns the second object byte.
// Assumes: Asynchronous read; contents fixed by an address hash.
// Notes:   The hash lets the bench predict every byte without a table.
`timescale 1ns/1ps
module bie_prog_mem
    import bie_pkg::*;
(
    // Fetch address.
    input  wire logic [ADDR_W-1:0] addr_i,
    // Read data.
    output logic      [DATA_W-1:0] data_o
);
    // ========================================================================
    // Read path.
    // Page bits are folded in so that branch targets differ across pages.
    logic [ADDR_W-1:0] mix;  // Scrambled address.
    assign mix    = addr_i * 12'h007 + {addr_i[3:0], addr_i[11:4]};
    assign data_o = mix[DATA_W-1:0] ^ 8'h5a;
endmodule

/* branch_increment_or_exec_tb_top.sv */
// Purpose: Self-checking bench for the branch, increment and OR slice.
// Assumes: Program memory feeds the second byte from address pc plus one.
// Notes:   A reference model in the bench predicts pc, accumulator and statuses.
`timescale 1ns/1ps
module branch_increment_or_exec_tb_top
    import bie_pkg::*;
;
    // ========================================================================
    // Design signals.
    logic                 clock_i, rst_n_i, exec_i, reg_wr_i, stat_wr_i;
    bie_op_t              op_i;
    logic [REG_SEL_W-1:0] reg_sel_i, reg_wr_sel_i;
    logic [DATA_W-1:0]    byte2_i, acc_wr_data_i, acc_o;
    logic [ADDR_W-1:0]    target_i, reg_wr_data_i, pc_o, fetch_addr;
    logic                 carry_wr_i, half_wr_i, nonzero_wr_i;
    logic                 carry_o, half_o, nonzero_o, busy_o, done_o;
    logic [2:0]           depth_o;
    // Reference model state.
    logic [ADDR_W-1:0]    m_pc, m_reg[8], m_stk[8];
    logic [DATA_W-1:0]    m_acc;
    logic                 m_c, m_h, m_a;
    logic [2:0]           m_dep;
    int                   n_mismatch = 0;
    int                   checks_done = 0;
    assign fetch_addr = pc_o + 12'h001;
    bie_exec #(.DEPTH(8)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .exec_i(exec_i),
        .op_i(op_i), .reg_sel_i(reg_sel_i), .byte2_i(byte2_i), .target_i(target_i),
        .reg_wr_i(reg_wr_i), .reg_wr_sel_i(reg_wr_sel_i), .reg_wr_data_i(reg_wr_data_i),
        .stat_wr_i(stat_wr_i), .acc_wr_data_i(acc_wr_data_i), .carry_wr_i(carry_wr_i),
        .half_wr_i(half_wr_i), .nonzero_wr_i(nonzero_wr_i), .pc_o(pc_o), .acc_o(acc_o),
        .carry_o(carry_o), .half_o(half_o), .nonzero_o(nonzero_o), .depth_o(depth_o),
        .busy_o(busy_o), .done_o(done_o));
    bie_prog_mem mem_u (.addr_i(fetch_addr), .data_o(byte2_i));
    // ========================================================================
    // Clock and watchdog; the run needs well under ten thousand cycles.
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    initial begin
        repeat (60000) @(posedge clock_i);
        n_mismatch++;
        stop_test();
    end
    // ========================================================================
    // Helpers and compare tasks.
    function automatic logic [7:0] rom_byte(input logic [11:0] a);
        logic [11:0] mix;
        mix = a * 12'h007 + {a[3:0], a[11:4]};
        return mix[7:0] ^ 8'h5a;
    endfunction
    task automatic stop_test();
        if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic bad(input string what);
        n_mismatch++;
        $display("[ERR] %0t %s", $time, what);
    endtask
    task automatic chk_pc(input logic [11:0] exp);
        checks_done++;
        if (pc_o !== exp) bad($sformatf("pc %h expected %h", pc_o, exp));
    endtask
    task automatic chk_acc(input logic [7:0] exp);
        checks_done++;
        if (acc_o !== exp) bad($sformatf("acc %h expected %h", acc_o, exp));
    endtask
    task automatic chk_flags(input logic [2:0] exp);
        checks_done++;
        if ({carry_o, half_o, nonzero_o} !== exp) bad("status flags differ");
    endtask
    task automatic chk_depth(input logic [2:0] exp);
        checks_done++;
        if (depth_o !== exp) bad($sformatf("depth %h expected %h", depth_o, exp));
    endtask
    task automatic chk_lat(input int got, input int exp);
        checks_done++;
        if (got != exp) bad($sformatf("latency %0d expected %0d", got, exp));
    endtask
    // Preloads take two edges: raise, then drop, so no strobe is assigned twice.
    task automatic preload_reg(input logic [2:0] sel, input logic [11:0] val);
        @(posedge clock_i);
        reg_wr_i      <= 1'b1;
        reg_wr_sel_i  <= sel;
        reg_wr_data_i <= val;
        @(posedge clock_i);
        reg_wr_i      <= 1'b0;
        m_reg[sel] = val;
    endtask
    task automatic preload_stat(input logic [7:0] acc, input logic [2:0] f);
        @(posedge clock_i);
        stat_wr_i     <= 1'b1;
        acc_wr_data_i <= acc;
        {carry_wr_i, half_wr_i, nonzero_wr_i} <= f;
        @(posedge clock_i);
        stat_wr_i     <= 1'b0;
        {m_acc, m_c, m_h, m_a} = {acc, f};
    endtask
    // Issue one operation, update the model, then compare latency, pc, accumulator, statuses and stack depth.
    task automatic exec_op(input bie_op_t op, input logic [2:0] sel, input logic [11:0] tgt);
        logic [11:0] nxt;
        logic [11:0] rel;
        logic        take;
        logic        is_rel;
        int          k;
        nxt    = m_pc + 12'h002;
        rel    = {nxt[11:8], rom_byte(m_pc + 12'h001)};
        is_rel = 1'b1;
        take   = 1'b0;
        @(posedge clock_i);
        exec_i    <= 1'b1;
        op_i      <= op;
        reg_sel_i <= sel;
        target_i  <= tgt;
        @(posedge clock_i);
        exec_i    <= 1'b0;
        case (op)
            bie_reg_increment_op: begin
                m_reg[sel] = m_reg[sel] + 12'h001;
                is_rel = 1'b0;
                m_pc   = m_pc + 12'h001;
            end
            bie_inclusive_or_op: begin
                m_acc  = m_acc | m_reg[sel][7:0];
                {m_c, m_h, m_a} = {2'b00, |m_acc};
                is_rel = 1'b0;
                m_pc   = m_pc + 12'h001;
            end
            bie_increment_branch_op, bie_decrement_branch_op: begin
                m_reg[sel] = (op == bie_increment_branch_op) ? m_reg[sel] + 12'h001
                                                             : m_reg[sel] - 12'h001;
                take = |m_reg[sel][7:0];
            end
            bie_jump_on_carry_op, bie_jump_less_op: take = m_c;
            bie_jump_no_carry_op, bie_jump_greater_equal_op: take = !m_c;
            bie_jump_greater_op: take = !m_c && m_a;
            bie_jump_half_carry_op: take = m_h;
            bie_jump_less_equal_op: take = m_c || !m_a;
            bie_jump_nonzero_op, bie_jump_not_equal_op: take = m_a;
            bie_jump_zero_op, bie_jump_equal_op: take = !m_a;
            default: begin
                is_rel = 1'b0;
                if (op == bie_subroutine_call_op) begin
                    m_stk[m_dep] = nxt;
                    m_dep++;
                end
                if (op == bie_subroutine_return_op) m_dep--;
                m_pc = (op == bie_register_indirect_jump_op) ? m_reg[sel] :
                       (op == bie_subroutine_return_op) ? m_stk[m_dep] : tgt;
            end
        endcase
        if (is_rel) m_pc = take ? rel : nxt;
        #1 chk_lat(busy_o === 1'b1, op == bie_subroutine_return_op);
        for (k = 1; k < 4 && done_o !== 1'b1; k++) begin
            @(posedge clock_i);
            #1;
        end
        chk_lat(k, (op == bie_subroutine_return_op) ? 2 : 1);
        chk_pc(m_pc);
        chk_acc(m_acc);
        chk_flags({m_c, m_h, m_a});
        chk_depth(m_dep);
    endtask
    // ========================================================================
    // Main sequence: reset, every operation once, corners, then random mix.
    initial begin
        static logic [11:0] corner[4] = '{12'hfff, 12'h2ff, 12'h0ff, 12'h23a};
        logic [2:0]  sel;
        bie_op_t     op;
        int          seed;
        {exec_i, reg_wr_i, stat_wr_i, carry_wr_i, half_wr_i, nonzero_wr_i} = '0;
        {reg_sel_i, reg_wr_sel_i, acc_wr_data_i, target_i, reg_wr_data_i} = '0;
        op_i    = bie_reg_increment_op;
        rst_n_i = 1'b0;
        {m_pc, m_acc, m_c, m_h, m_a, m_dep} = '0;
        foreach (m_reg[i]) m_reg[i] = 12'h000;
        seed = $urandom(16197);
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        #1;
        chk_pc(12'h000);
        for (int j = 0; j < 19; j++) exec_op(bie_op_t'(j > 16 ? 35 - j : j), j[2:0], 12'h3fa);
        foreach (corner[i]) begin
            preload_reg(3'h1, corner[i]);
            exec_op(bie_reg_increment_op, 3'h1, 12'h000);
            exec_op(bie_register_indirect_jump_op, 3'h1, 12'h000);
        end
        for (int i = 0; i < 400; i++) begin
            sel = 3'($urandom_range(0, 7));
            if ($urandom_range(0, 3) == 0) preload_stat(8'($urandom), 3'($urandom));
            if ($urandom_range(0, 2) == 0)
                preload_reg(sel, ($urandom_range(0, 1) == 0) ? corner[$urandom_range(0, 3)]
                                                             : 12'($urandom));
            if ($urandom_range(0, 3) == 0) begin
                // Park pc at the last bytes of a page to force straddling branches.
                preload_reg(3'h7, {4'($urandom), 7'h7f, 1'($urandom)});
                exec_op(bie_register_indirect_jump_op, 3'h7, 12'h000);
            end
            op = bie_op_t'($urandom_range(0, 18));
            if (op == bie_subroutine_return_op && m_dep == 3'h0) op = bie_subroutine_call_op;
            if (op == bie_subroutine_call_op && m_dep == 3'h7) op = bie_subroutine_return_op;
            exec_op(op, sel, 12'($urandom));
        end
        stop_test();
    end
endmodule
